// ===== src/cpirq_top.sv
// Interrupt enable/status and key-store control for the content-protection
// transmitter. Assumes event inputs are one-cycle pulses from the auth engine
// and that the control-bus slave presents byte reads and writes on the port.
`timescale 1ns/1ps
`default_nettype none
module cpirq_top
	import cpirq_pkg::*;
#(
	parameter int KEY_DEPTH = CPIRQ_KEY_DEPTH,
	parameter int KEY_AW    = CPIRQ_KEY_AW
) (
	input  wire logic               clock,
	input  wire logic               nrst,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [7:0]         reg_rdata_reg,
	input  wire logic               indirect_done,
	input  wire logic               receiver_detect,
	input  wire logic               receiver_lock,
	input  wire logic               detect_waits_for_lock,
	input  wire logic               downstream_irq_n,
	input  wire logic               key_list_ready,
	input  wire logic               key_ready,
	input  wire logic               auth_failure,
	input  wire logic               auth_success,
	input  wire logic               verify_start,
	input  wire logic               verify_done,
	input  wire logic               verify_ok,
	input  wire logic               key_store_data0,
	input  wire logic [7:0]         red_pins,
	input  wire logic               green0_pin,
	input  wire logic [KEY_AW-1:0]  key_rd_addr,
	output logic      [7:0]         key_rd_data_reg,
	output logic                    irq_n_reg,
	output logic                    parallel_load_on_reg
);
	// Register state
	logic [7:0] enable_reg;
	logic [7:1] flags_reg;
	logic [7:1] flags_next;
	logic [7:0] enable_next;
	logic       global_reg;
	logic       verify_passed_reg;
	logic       verify_finished_reg;
	logic       found_level_reg;
	logic       down_level_reg;

	// Decoded strobes
	logic       wr_enable;
	logic       wr_keyctl;
	logic       rd_status;
	logic       found_level;
	logic       found_rise;
	logic       down_rise;
	logic [7:1] set_vec;

	// Loader to memory
	logic              ld_wr_en;
	logic [KEY_AW-1:0] ld_wr_addr;
	logic [7:0]        ld_wr_data;

	// Register hit test, used by every access decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	assign wr_enable = reg_wr & hit(reg_addr, CPIRQ_OFS_ENABLE);
	assign wr_keyctl = reg_wr & hit(reg_addr, CPIRQ_OFS_KEYCTL);
	assign rd_status = reg_rd & hit(reg_addr, CPIRQ_OFS_STATUS);

	assign found_level = receiver_detect & (~detect_waits_for_lock | receiver_lock);
	assign found_rise  = found_level & ~found_level_reg;
	assign down_rise   = ~downstream_irq_n & ~down_level_reg;

	// Source events in status bit order
	always_comb begin
		set_vec                    = '0;
		set_vec[CPIRQ_BIT_INDIRECT] = indirect_done;
		set_vec[CPIRQ_BIT_RECEIVER] = found_rise;
		set_vec[CPIRQ_BIT_DOWNSTRM] = down_rise;
		set_vec[CPIRQ_BIT_KEYLIST]  = key_list_ready;
		set_vec[CPIRQ_BIT_KEY]      = key_ready;
		set_vec[CPIRQ_BIT_AUTHFAIL] = auth_failure;
		set_vec[CPIRQ_BIT_AUTHPASS] = auth_success;
	end

	// Source flags clear on a status read; a new event in the same cycle wins
	always_comb begin
		flags_next = flags_reg;
		if (rd_status) begin
			flags_next = '0;
		end
		flags_next = flags_next | set_vec;
	end

	// Edge history for level sources
	always_ff @(posedge clock) begin
		if (!nrst) begin
			found_level_reg <= 1'b0;
			down_level_reg  <= 1'b0;
		end else begin
			found_level_reg <= found_level;
			down_level_reg  <= ~downstream_irq_n;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			enable_reg <= CPIRQ_RST_ENABLE;
		end else if (wr_enable) begin
			enable_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			flags_reg <= CPIRQ_RST_STATUS[7:1];
		end else begin
			flags_reg <= flags_next;
		end
	end

	// Mask as of the next edge, so the global flag never lags a mask write
	always_comb begin
		enable_next = enable_reg;
		if (wr_enable) begin
			enable_next = reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			global_reg <= 1'b0;
		end else begin
			global_reg <= |(flags_next & enable_next[7:1]);
		end
	end

	// Interrupt output, gated by global enable
	always_ff @(posedge clock) begin
		if (!nrst) begin
			irq_n_reg <= 1'b1;
		end else begin
			irq_n_reg <= ~(global_reg & enable_reg[CPIRQ_BIT_GLOBAL]);
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			verify_finished_reg <= CPIRQ_RST_KEYCTL[CPIRQ_BIT_VDONE];
			verify_passed_reg   <= CPIRQ_RST_KEYCTL[CPIRQ_BIT_VPASS];
		end else if (verify_done) begin
			verify_finished_reg <= 1'b1;
			verify_passed_reg   <= verify_ok;
		end else if (verify_start) begin
			verify_finished_reg <= 1'b0;
			verify_passed_reg   <= 1'b0;
		end
	end

	// Parallel load enable, only writable control bit
	always_ff @(posedge clock) begin
		if (!nrst) begin
			parallel_load_on_reg <= CPIRQ_RST_KEYCTL[CPIRQ_BIT_PARALLEL];
		end else if (wr_keyctl) begin
			parallel_load_on_reg <= reg_wdata[CPIRQ_BIT_PARALLEL];
		end
	end

	// Register read mux; unmapped offsets read zero
	always_ff @(posedge clock) begin
		if (!nrst) begin
			reg_rdata_reg <= CPIRQ_ZERO_BYTE;
		end else if (reg_rd) begin
			if (hit(reg_addr, CPIRQ_OFS_ENABLE)) begin
				reg_rdata_reg <= enable_reg;
			end else if (hit(reg_addr, CPIRQ_OFS_STATUS)) begin
				reg_rdata_reg <= {flags_reg, global_reg};
			end else if (hit(reg_addr, CPIRQ_OFS_KEYCTL)) begin
				reg_rdata_reg <= {verify_passed_reg, verify_finished_reg,
					parallel_load_on_reg, 5'h00};
			end else begin
				reg_rdata_reg <= CPIRQ_ZERO_BYTE;
			end
		end
	end

	// Parallel loader; key_store_data0 gates each byte write
	cpirq_loader #(
		.AW (KEY_AW)
	) u_loader (
		.clock       (clock),
		.nrst        (nrst),
		.load_on     (parallel_load_on_reg),
		.mem_clk_pin (green0_pin),
		.data_pin    (red_pins),
		.write_gate  (key_store_data0),
		.wr_en_reg   (ld_wr_en),
		.wr_addr_reg (ld_wr_addr),
		.wr_data_reg (ld_wr_data)
	);

	// Key store memory
	cpirq_key_ram #(
		.DEPTH (KEY_DEPTH),
		.AW    (KEY_AW)
	) u_ram (
		.clock       (clock),
		.wr_en       (ld_wr_en),
		.wr_addr     (ld_wr_addr),
		.wr_data     (ld_wr_data),
		.rd_addr     (key_rd_addr),
		.rd_data_reg (key_rd_data_reg)
	);

	// Checks on the interrupt path and key-store control
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	enable_write_a: assert property (
		wr_enable |=> enable_reg == $past(reg_wdata))
		else $error("enable register did not take write");

	found_gate_a: assert property (
		detect_waits_for_lock && !receiver_lock && !rd_status
		&& !flags_reg[CPIRQ_BIT_RECEIVER] |=> !flags_reg[CPIRQ_BIT_RECEIVER])
		else $error("receiver flag set without lock");

	down_flag_a: assert property (
		down_rise |=> flags_reg[CPIRQ_BIT_DOWNSTRM])
		else $error("downstream request not flagged");

	indirect_flag_a: assert property (
		indirect_done |=> flags_reg[CPIRQ_BIT_INDIRECT])
		else $error("indirect done not flagged");

	set_wins_a: assert property (
		rd_status && auth_failure |=> flags_reg[CPIRQ_BIT_AUTHFAIL])
		else $error("failure event lost on clearing read");

	global_flag_a: assert property (
		|(flags_reg & enable_reg[7:1]) |-> global_reg)
		else $error("global flag missing for enabled source");

	irq_gate_a: assert property (
		!irq_n_reg |-> $past(enable_reg[CPIRQ_BIT_GLOBAL]) && $past(global_reg))
		else $error("interrupt asserted without global enable");

	irq_follow_a: assert property (
		global_reg && enable_reg[CPIRQ_BIT_GLOBAL] |=> !irq_n_reg)
		else $error("interrupt output not asserted");

	verify_done_a: assert property (
		verify_done |=> verify_finished_reg && verify_passed_reg == $past(verify_ok))
		else $error("verify result not captured");

	load_write_a: assert property (
		ld_wr_en |-> $past(parallel_load_on_reg) && $past(key_store_data0))
		else $error("key write outside parallel load");

	global_exact_a: assert property (
		global_reg == |(flags_reg & enable_reg[7:1]))
		else $error("global flag disagrees with enabled sources");

	irq_release_a: assert property (
		!enable_reg[CPIRQ_BIT_GLOBAL] |=> irq_n_reg)
		else $error("interrupt asserted while globally disabled");

	list_flag_a: assert property (
		key_list_ready |=> flags_reg[CPIRQ_BIT_KEYLIST])
		else $error("key list ready not flagged");

	key_flag_a: assert property (
		key_ready |=> flags_reg[CPIRQ_BIT_KEY])
		else $error("key ready not flagged");

	pass_flag_a: assert property (
		auth_success |=> flags_reg[CPIRQ_BIT_AUTHPASS])
		else $error("authentication pass not flagged");

	found_flag_a: assert property (
		found_rise |=> flags_reg[CPIRQ_BIT_RECEIVER])
		else $error("receiver found not flagged");

	read_clear_a: assert property (
		rd_status && !indirect_done |=> !flags_reg[CPIRQ_BIT_INDIRECT])
		else $error("indirect flag survived status read");

	load_bit_a: assert property (
		wr_keyctl |=> parallel_load_on_reg == $past(reg_wdata[CPIRQ_BIT_PARALLEL]))
		else $error("parallel load bit did not take write");

	verify_clear_a: assert property (
		verify_start && !verify_done |=> !verify_finished_reg)
		else $error("verify done not cleared by start");

	irq_seen_c: cover property (|set_vec && enable_reg[CPIRQ_BIT_GLOBAL] ##[1:3] !irq_n_reg);
	clear_read_c: cover property (!irq_n_reg ##1 rd_status ##2 irq_n_reg);
	key_write_c: cover property (ld_wr_en ##[1:20] ld_wr_en);
	verify_c: cover property (verify_start ##[1:50] verify_done);
endmodule
`default_nettype wire

// ===== src/cpirq_pkg.sv
// Constants for the content-protection interrupt and key-store control block.
// Assumes a single core clock and a byte-wide register port from the control bus.
package cpirq_pkg;

	// Register offsets
	localparam logic [7:0] CPIRQ_OFS_ENABLE  = 8'hc6;
	localparam logic [7:0] CPIRQ_OFS_STATUS  = 8'hc7;
	localparam logic [7:0] CPIRQ_OFS_KEYCTL  = 8'hc8;

	// Reset values
	localparam logic [7:0] CPIRQ_RST_ENABLE  = 8'h00;
	localparam logic [7:0] CPIRQ_RST_STATUS  = 8'h00;
	localparam logic [7:0] CPIRQ_RST_KEYCTL  = 8'h00;
	localparam logic [7:0] CPIRQ_ZERO_BYTE   = 8'h00;

	// Enable and status field positions (shared layout)
	localparam int CPIRQ_BIT_INDIRECT  = 7;
	localparam int CPIRQ_BIT_RECEIVER  = 6;
	localparam int CPIRQ_BIT_DOWNSTRM  = 5;
	localparam int CPIRQ_BIT_KEYLIST   = 4;
	localparam int CPIRQ_BIT_KEY       = 3;
	localparam int CPIRQ_BIT_AUTHFAIL  = 2;
	localparam int CPIRQ_BIT_AUTHPASS  = 1;
	localparam int CPIRQ_BIT_GLOBAL    = 0;

	// Key-store control field positions
	localparam int CPIRQ_BIT_VPASS     = 7;
	localparam int CPIRQ_BIT_VDONE     = 6;
	localparam int CPIRQ_BIT_PARALLEL  = 5;

	// Key-store geometry
	localparam int CPIRQ_KEY_DEPTH     = 512;
	localparam int CPIRQ_KEY_AW        = 9;

	// Parallel loader states
	typedef enum logic [1:0] {
		CPIRQ_LD_IDLE = 2'b01,
		CPIRQ_LD_LOAD = 2'b10
	} cpirq_ld_state_t;

endpackage

// ===== src/cpirq_key_ram.sv
// Single-port write, registered-read memory holding the protection keys.
// Assumes one clock; write and read may occur in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module cpirq_key_ram #(
	parameter int DEPTH = cpirq_pkg::CPIRQ_KEY_DEPTH,
	parameter int AW    = cpirq_pkg::CPIRQ_KEY_AW
) (
	input  wire logic          clock,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data_reg
);
	logic [7:0] mem [DEPTH];

	// Write port, no reset so it maps to block memory
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Read data always comes from a register
	always_ff @(posedge clock) begin
		rd_data_reg <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ===== src/cpirq_loader.sv
// Parallel key loader: samples the memory clock pin and red data byte, and
// writes one byte per rising edge that has the write gate high, while loading is enabled.
// Assumes pins are already synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module cpirq_loader
	import cpirq_pkg::*;
#(
	parameter int AW = CPIRQ_KEY_AW
) (
	input  wire logic          clock,
	input  wire logic          nrst,
	input  wire logic          load_on,
	input  wire logic          mem_clk_pin,
	input  wire logic [7:0]    data_pin,
	input  wire logic          write_gate,
	output logic               wr_en_reg,
	output logic [AW-1:0]      wr_addr_reg,
	output logic [7:0]         wr_data_reg
);
	cpirq_ld_state_t state_reg;
	logic            clk_pin_reg;
	logic [AW-1:0]   addr_reg;
	logic            rise;

	assign rise = mem_clk_pin & ~clk_pin_reg;

	// Mode tracking; address restarts each time loading is switched on
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_reg <= CPIRQ_LD_IDLE;
		end else begin
			unique case (state_reg)
				CPIRQ_LD_IDLE: state_reg <= load_on ? CPIRQ_LD_LOAD : CPIRQ_LD_IDLE;
				CPIRQ_LD_LOAD: state_reg <= load_on ? CPIRQ_LD_LOAD : CPIRQ_LD_IDLE;
			endcase
		end
	end

	// Pin edge detect and byte capture
	always_ff @(posedge clock) begin
		if (!nrst) begin
			clk_pin_reg <= 1'b0;
			addr_reg    <= '0;
			wr_en_reg   <= 1'b0;
			wr_addr_reg <= '0;
			wr_data_reg <= CPIRQ_ZERO_BYTE;
		end else begin
			clk_pin_reg <= mem_clk_pin;
			wr_en_reg   <= 1'b0;
			if (state_reg == CPIRQ_LD_IDLE) begin
				addr_reg <= '0;
			end else if (rise && write_gate && load_on) begin
				wr_en_reg   <= 1'b1;
				wr_addr_reg <= addr_reg;
				wr_data_reg <= data_pin;
				addr_reg    <= addr_reg + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== sim/cpirq_host.sv
// Host controller model: byte-wide master on the register port of the block.
// Assumes the bench calls its tasks one at a time, never from two processes.
`timescale 1ns/1ps
`default_nettype none
module cpirq_host (
	input  wire logic  clock,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic       reg_wr,
	output logic       reg_rd
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One write, held over exactly one sampling edge, then released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_addr = ~a; // Released lines show the inverse, not a stale value
		reg_wdata = ~d;
	endtask

	// result read with done
	// One read strobe; the data is taken by the bench a cycle later
	task automatic rd(input logic [7:0] a);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge clock);
	endtask
endmodule
`default_nettype wire

// ===== sim/content_protect_irq_and_key_verify_bench.sv
// Self-checking bench for the interrupt and key-store control block.
// Assumes the host model in its own file and the design sources under src.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module content_protect_irq_and_key_verify_bench;
	import cpirq_pkg::*;
	logic clock, nrst, ind, rdet, rlock, wlock, ds_n, klist, key, afail, apass;
	logic vstart, vdone, vok, gate, green;
	logic [7:0] red, reg_addr, reg_wdata, rdata, kdata, en, seed, want;
	logic reg_wr, reg_rd, irq_n, pload;
	logic [8:0] kaddr;
	logic [7:0] expq[$];
	int error_cnt, num_checks;

	cpirq_host host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd));
	cpirq_top dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_reg(rdata), .indirect_done(ind),
		.receiver_detect(rdet), .receiver_lock(rlock), .detect_waits_for_lock(wlock),
		.downstream_irq_n(ds_n), .key_list_ready(klist), .key_ready(key),
		.auth_failure(afail), .auth_success(apass), .verify_start(vstart),
		.verify_done(vdone), .verify_ok(vok), .key_store_data0(gate), .red_pins(red),
		.green0_pin(green), .key_rd_addr(kaddr), .key_rd_data_reg(kdata),
		.irq_n_reg(irq_n), .parallel_load_on_reg(pload));

	// Free-running core clock, 8 ns period
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic stop_test;
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Note the expected byte, then issue the read
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		host.rd(a);
	endtask

	// Read data stands one cycle after the strobe; take the oldest note then
	always @(posedge clock) begin
		if (reg_rd === 1'b1) begin
			@(negedge clock);
			want = expq.pop_front();
			`CHK(rdata, want)
		end
	end

	task automatic pulse(input int b);
		@(negedge clock);
		case (b)
			7: ind = 1'b1;
			4: klist = 1'b1;
			3: key = 1'b1;
			2: afail = 1'b1;
			default: apass = 1'b1;
		endcase
		@(negedge clock);
		{ind, klist, key, afail, apass} = 5'h00;
	endtask

	// Source b has just fired: check the line, the flags, then clear on read
	task automatic chk_ev(input int b);
		repeat (4) @(negedge clock);
		`CHK(irq_n, ~(en[b] & en[0]))
		rd(CPIRQ_OFS_STATUS, 8'(1 << b) | {7'h00, en[b]});
		repeat (4) @(negedge clock);
		`CHK(irq_n, 1'b1)
		rd(CPIRQ_OFS_STATUS, 8'h00);
	endtask

	task automatic new_en;
		seed = lfsr(seed);
		en = seed;
		host.wr(CPIRQ_OFS_ENABLE, en);
		rd(CPIRQ_OFS_ENABLE, en);
	endtask

	task automatic ld(input logic [7:0] d, input logic g);
		@(negedge clock);
		red = d;
		gate = g;
		green = 1'b1;
		@(negedge clock);
		green = 1'b0;
		red = ~d;
		@(negedge clock);
	endtask

	task automatic key_chk(input logic [8:0] a, input logic [7:0] e);
		@(negedge clock);
		kaddr = a;
		@(negedge clock);
		`CHK(kdata, e)
	endtask

	// Watchdog sized well beyond the sequence below
	initial begin
		#100000;
		error_cnt++;
		stop_test;
	end

	initial begin
		{ind, rdet, rlock, wlock, klist, key, afail, apass} = 8'h00;
		{vstart, vdone, vok, gate, green} = 5'h00;
		ds_n = 1'b1;
		red = 8'h00;
		kaddr = 9'h000;
		seed = 8'h33;
		en = 8'h00;
		error_cnt = 0;
		num_checks = 0;
		nrst = 1'b0;
		repeat (3) @(posedge clock);
		@(negedge clock);
		nrst = 1'b1;
		`CHK(irq_n, 1'b1)
		rd(CPIRQ_OFS_ENABLE, CPIRQ_RST_ENABLE);
		rd(CPIRQ_OFS_STATUS, CPIRQ_RST_STATUS);
		rd(CPIRQ_OFS_KEYCTL, CPIRQ_RST_KEYCTL);
		rd(8'h55, 8'h00);
		host.wr(CPIRQ_OFS_ENABLE, 8'hff);
		rd(CPIRQ_OFS_ENABLE, 8'hff);
		host.wr(CPIRQ_OFS_STATUS, 8'hff);
		rd(CPIRQ_OFS_STATUS, 8'h00);
		// Pulse sources, each under a random enable mask
		for (int i = 0; i < 8; i++) begin
			if (i == 7 || (i >= 1 && i <= 4)) begin
				new_en;
				pulse(i);
				chk_ev(i);
			end
		end
		// Receiver found without and with the wait for lock
		new_en;
		@(negedge clock);
		rdet = 1'b1;
		chk_ev(6);
		rdet = 1'b0;
		wlock = 1'b1;
		@(negedge clock);
		rdet = 1'b1;
		repeat (4) @(negedge clock);
		rd(CPIRQ_OFS_STATUS, 8'h00);
		rlock = 1'b1;
		chk_ev(6);
		{rdet, rlock} = 2'b00;
		// Downstream request flagged on its falling edge
		new_en;
		@(negedge clock);
		ds_n = 1'b0;
		chk_ev(5);
		ds_n = 1'b1;
		// Verify result and done, then the writable load bit only
		@(negedge clock);
		{vdone, vok} = 2'b11;
		@(negedge clock);
		{vdone, vok} = 2'b00;
		rd(CPIRQ_OFS_KEYCTL, 8'hc0);
		@(negedge clock);
		vstart = 1'b1;
		@(negedge clock);
		vstart = 1'b0;
		rd(CPIRQ_OFS_KEYCTL, 8'h00);
		@(negedge clock);
		vdone = 1'b1;
		@(negedge clock);
		vdone = 1'b0;
		host.wr(CPIRQ_OFS_KEYCTL, 8'hff);
		rd(CPIRQ_OFS_KEYCTL, 8'h60);
		`CHK(pload, 1'b1)
		// Parallel load: a gated-off edge must not take a byte or an address
		seed = lfsr(seed);
		ld(8'haa, 1'b1);
		ld(8'h33, 1'b0);
		ld(seed, 1'b1);
		key_chk(9'h000, 8'haa);
		key_chk(9'h001, seed);
		host.wr(CPIRQ_OFS_KEYCTL, 8'h00);
		rd(CPIRQ_OFS_KEYCTL, 8'h40);
		`CHK(pload, 1'b0)
		stop_test;
	end
endmodule
`default_nettype wire
